// ===== common/dac_regs_consts.vh
`ifndef DAC_REGS_CONSTS_VH
`define DAC_REGS_CONSTS_VH

// register addresses, 8-bit address space
`define ADDR_POWER_DOWN_CONTROL  8'h18
`define ADDR_OUTPUT_SPAN_SELECT  8'h19
`define ADDR_LOAD_PIN_IGNORE     8'h28
`define ADDR_OUTPUT_CODE         8'h29
`define ADDR_BCAST_OUTPUT_CODE   8'h2D
`define ADDR_PAGE_COPY_SELECT    8'h2F
`define ADDR_BCAST_INPUT_CODE    8'h30
`define ADDR_SW_LOAD_TRIGGER     8'h32
`define ADDR_STAGED_INPUT_CODE   8'h33

// field positions
`define BIT_DAC_CORE_SLEEP       4
`define BIT_AMP_SLEEP            0
`define BIT_LOAD_PIN_IGNORE      0
`define BIT_CHANNEL_COPY_ENABLE  0
`define BIT_SW_LOAD_TRIGGER      0

// span encodings
`define SPAN_0_2V5               3'h0
`define SPAN_0_5V                3'h1
`define SPAN_0_10V               3'h2
`define SPAN_PM_5V               3'h3
`define SPAN_M2V5_7V5            3'h4

// reset values
`define RST_BYTE                 8'h00
`define RST_CODE                 16'h0000

`endif

// ===== src/dac_fast_mode_update_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "dac_regs_consts.vh"

// Overview of operation
// - dac core sleep bit 4 powers down the converter core.
// - amp sleep bit 0 powers down the output amplifier.
// - span field [3:0] values 0 to 4 decode to five output ranges; other values clear span_valid.
// - with pin ignore clear, load strobe low copies staged code to output.
// - with pin ignore set, load strobe leaves output code unchanged.
// - 16-bit output code drives converter; read/write, resets to zero.
// - broadcast output write copies to output code when copy enabled.
// - broadcast input write copies to staged code when copy enabled.
// - copy enable bit 0 gates both broadcast copies.
// - writing one to trigger bit loads staged code into output.
// - trigger bit clears itself; reads back zero.
// - software trigger acts like a load strobe low pulse, but pin ignore does not block it.
// - staged input register holds pending code for any load path.
module dac_fast_mode_update_regs (
   input  wire        ref_clk,
   input  wire        nrst,
   input  wire        load_strobe_n,
   input  wire        wr_en,
   input  wire        rd_en,
   input  wire [7:0]  addr,
   input  wire [15:0] wr_data,
   output reg  [15:0] rd_data,
   output reg         rd_valid,
   output reg  [15:0] dac_code,
   output reg         dac_core_sleep,
   output reg         amp_sleep,
   output reg  [2:0]  span_code,
   output reg         span_valid
);

   reg        rst_meta_ff;
   reg        rst_sync_ff;
   wire       rst_n;
   reg        strobe_meta_ff;
   reg        strobe_sync_ff;
   reg        strobe_prev_ff;
   reg [7:0]  power_down_control_ff;
   reg [3:0]  span_select_ff;
   reg        load_pin_ignore_ff;
   reg        channel_copy_enable_ff;
   reg [15:0] output_code_ff;
   reg [15:0] bcast_output_ff;
   reg [15:0] bcast_input_ff;
   reg [15:0] staged_code_ff;
   reg [15:0] nxt_output_code;
   reg [15:0] nxt_staged_code;
   reg [15:0] nxt_rd_data;
   wire       hw_load;
   wire       sw_load;
   wire       do_load;
   wire       wr_power_down;
   wire       wr_span_select;
   wire       wr_pin_ignore;
   wire       wr_output_code;
   wire       wr_bcast_output;
   wire       wr_copy_select;
   wire       wr_bcast_input;
   wire       wr_sw_trigger;
   wire       wr_staged_code;

   // the two sleep bits are the only stored bits of the power register
   localparam [7:0] sleep_bits_mask = (8'h01 << `BIT_DAC_CORE_SLEEP) | (8'h01 << `BIT_AMP_SLEEP);

   // wr_en goes in as an argument so that @* and assign see it change
   function is_wr;
      input       en;
      input [7:0] a;
      input [7:0] target;
      begin
         is_wr = en && (a == target);
      end
   endfunction

   function span_is_defined;
      input [3:0] sel;
      begin
         case (sel)
            {1'b0, `SPAN_0_2V5}:    span_is_defined = 1'b1;
            {1'b0, `SPAN_0_5V}:     span_is_defined = 1'b1;
            {1'b0, `SPAN_0_10V}:    span_is_defined = 1'b1;
            {1'b0, `SPAN_PM_5V}:    span_is_defined = 1'b1;
            {1'b0, `SPAN_M2V5_7V5}: span_is_defined = 1'b1;
            default:                span_is_defined = 1'b0;
         endcase
      end
   endfunction

   // one decoded write strobe per register
   assign wr_power_down   = is_wr(wr_en, addr, `ADDR_POWER_DOWN_CONTROL);
   assign wr_span_select  = is_wr(wr_en, addr, `ADDR_OUTPUT_SPAN_SELECT);
   assign wr_pin_ignore   = is_wr(wr_en, addr, `ADDR_LOAD_PIN_IGNORE);
   assign wr_output_code  = is_wr(wr_en, addr, `ADDR_OUTPUT_CODE);
   assign wr_bcast_output = is_wr(wr_en, addr, `ADDR_BCAST_OUTPUT_CODE);
   assign wr_copy_select  = is_wr(wr_en, addr, `ADDR_PAGE_COPY_SELECT);
   assign wr_bcast_input  = is_wr(wr_en, addr, `ADDR_BCAST_INPUT_CODE);
   assign wr_sw_trigger   = is_wr(wr_en, addr, `ADDR_SW_LOAD_TRIGGER);
   assign wr_staged_code  = is_wr(wr_en, addr, `ADDR_STAGED_INPUT_CODE);

   // reset release synchronised to ref_clk
   // nrst still asserts at once; only its release waits two edges
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_n = rst_sync_ff;

   // load strobe pin is asynchronous; edge detected on synchronised copy only
   // flops reset to the pin's idle high, so reset makes no false edge
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_meta_ff <= 1'b1;
         strobe_sync_ff <= 1'b1;
         strobe_prev_ff <= 1'b1;
      end else begin
         strobe_meta_ff <= load_strobe_n;
         strobe_sync_ff <= strobe_meta_ff;
         strobe_prev_ff <= strobe_sync_ff;
      end
   end

   // a pin held low loads once, on its falling edge
   // falling edge, gated by ignore bit
   assign hw_load = strobe_prev_ff && !strobe_sync_ff && !load_pin_ignore_ff;
   assign sw_load = wr_sw_trigger && wr_data[`BIT_SW_LOAD_TRIGGER];
   assign do_load = hw_load || sw_load;

   always @* begin
      nxt_staged_code = staged_code_ff;
      if (wr_staged_code) begin
         nxt_staged_code = wr_data;
      end
      if (wr_bcast_input && channel_copy_enable_ff) begin
         nxt_staged_code = wr_data;
      end
   end

   always @* begin
      nxt_output_code = output_code_ff;
      if (wr_output_code) begin
         nxt_output_code = wr_data;
      end
      if (wr_bcast_output && channel_copy_enable_ff) begin
         nxt_output_code = wr_data;
      end
      // load wins; uses the staged code before this cycle's write
      if (do_load) begin
         nxt_output_code = staged_code_ff;
      end
   end

   // power register keeps only its sleep bits
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_down_control_ff <= `RST_BYTE;
      end else if (wr_power_down) begin
         power_down_control_ff <= wr_data[7:0] & sleep_bits_mask;
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         span_select_ff <= 4'h0;
      end else if (wr_span_select) begin
         span_select_ff <= wr_data[3:0];
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         load_pin_ignore_ff <= 1'b0;
      end else if (wr_pin_ignore) begin
         load_pin_ignore_ff <= wr_data[`BIT_LOAD_PIN_IGNORE];
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         channel_copy_enable_ff <= 1'b0;
      end else if (wr_copy_select) begin
         channel_copy_enable_ff <= wr_data[`BIT_CHANNEL_COPY_ENABLE];
      end
   end

   // broadcast output kept for read back
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bcast_output_ff <= `RST_CODE;
      end else if (wr_bcast_output) begin
         bcast_output_ff <= wr_data;
      end
   end

   // broadcast input kept for read back
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bcast_input_ff <= `RST_CODE;
      end else if (wr_bcast_input) begin
         bcast_input_ff <= wr_data;
      end
   end

   // code registers take their next values
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         output_code_ff <= `RST_CODE;
         staged_code_ff <= `RST_CODE;
      end else begin
         output_code_ff <= nxt_output_code;
         staged_code_ff <= nxt_staged_code;
      end
   end

   // reserved and unmapped bits read zero
   always @* begin
      case (addr)
         `ADDR_POWER_DOWN_CONTROL: nxt_rd_data = {8'h00, power_down_control_ff};
         `ADDR_OUTPUT_SPAN_SELECT: nxt_rd_data = {12'h000, span_select_ff};
         `ADDR_LOAD_PIN_IGNORE:    nxt_rd_data = {15'h0000, load_pin_ignore_ff};
         `ADDR_OUTPUT_CODE:        nxt_rd_data = output_code_ff;
         `ADDR_BCAST_OUTPUT_CODE:  nxt_rd_data = bcast_output_ff;
         `ADDR_PAGE_COPY_SELECT:   nxt_rd_data = {15'h0000, channel_copy_enable_ff};
         `ADDR_BCAST_INPUT_CODE:   nxt_rd_data = bcast_input_ff;
         `ADDR_STAGED_INPUT_CODE:  nxt_rd_data = staged_code_ff;
         default:                  nxt_rd_data = 16'h0000;
      endcase
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 16'h0000;
      end else if (rd_en) begin
         rd_data <= nxt_rd_data;
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_en;
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_code <= `RST_CODE;
      end else begin
         dac_code <= output_code_ff;
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_core_sleep <= 1'b0;
      end else begin
         dac_core_sleep <= power_down_control_ff[`BIT_DAC_CORE_SLEEP];
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         amp_sleep <= 1'b0;
      end else begin
         amp_sleep <= power_down_control_ff[`BIT_AMP_SLEEP];
      end
   end

   // undefined span codes keep their low bits; only the flag drops
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         span_code  <= `SPAN_0_2V5;
         span_valid <= 1'b1;
      end else begin
         span_code  <= span_select_ff[2:0];
         span_valid <= span_is_defined(span_select_ff);
      end
   end

endmodule // dac_fast_mode_update_regs
`default_nettype wire

// ===== tb/dac_fast_mode_update_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dac_fast_mode_update_regs_bench;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic load_strobe_n = 1'b1;
   logic wr_en, rd_en, rd_valid, dac_core_sleep, amp_sleep, span_valid;
   logic [7:0] addr;
   logic [15:0] wr_data, rd_data, dac_code, q;
   logic [2:0] span_code;
   logic [7:0] regs [9] = '{8'h18, 8'h19, 8'h28, 8'h29, 8'h2D, 8'h2F, 8'h30, 8'h32, 8'h33};
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   always #50 ref_clk = ~ref_clk;
   reg_host u_host (.ref_clk(ref_clk), .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wr_data(wr_data));
   dac_fast_mode_update_regs u_dut (.ref_clk(ref_clk), .nrst(nrst), .load_strobe_n(load_strobe_n),
      .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
      .rd_valid(rd_valid), .dac_code(dac_code), .dac_core_sleep(dac_core_sleep),
      .amp_sleep(amp_sleep), .span_code(span_code), .span_valid(span_valid));
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      u_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      u_host.xfer(1'b0, a, 16'h0000, q);
      chk(q, e);
   endtask
   // pin held low three cycles, then high long enough for the next pulse
   task automatic pulse;
      @(negedge ref_clk);
      load_strobe_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      load_strobe_n = 1'b1;
      repeat (4) @(negedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         finish_test;
      end
   end
   initial begin
      repeat (8) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (3) @(negedge ref_clk);
      foreach (regs[i]) rd(regs[i], 16'h0000);
      $display("reset test done");
      wr(8'h18, 16'hFFFF);
      rd(8'h18, 16'h0011);
      chk({14'h0000, dac_core_sleep, amp_sleep}, 16'h0003);
      wr(8'h18, 16'h0010);
      chk({14'h0000, dac_core_sleep, amp_sleep}, 16'h0002);
      for (int s = 0; s < 6; s++) begin
         wr(8'h19, 16'hFFF0 | 16'(s));
         rd(8'h19, 16'(s));
         chk({12'h000, span_valid, span_code}, {12'h000, s < 5, 3'(s)});
      end
      $display("power and span test done");
      wr(8'h29, 16'hA55A);
      chk(dac_code, 16'hA55A);
      wr(8'h33, 16'h1234);
      chk(dac_code, 16'hA55A);
      wr(8'h32, 16'h0001);
      chk(dac_code, 16'h1234);
      rd(8'h29, 16'h1234);
      rd(8'h32, 16'h0000);
      wr(8'h2D, 16'hBEEF);
      chk(dac_code, 16'h1234);
      wr(8'h30, 16'h5678);
      rd(8'h33, 16'h1234);
      wr(8'h2F, 16'h0003);
      rd(8'h2F, 16'h0001);
      wr(8'h2D, 16'hBEEF);
      chk(dac_code, 16'hBEEF);
      wr(8'h30, 16'h5678);
      rd(8'h33, 16'h5678);
      $display("code path test done");
      pulse;
      chk(dac_code, 16'h5678);
      wr(8'h33, 16'h9ABC);
      wr(8'h28, 16'h0001);
      pulse;
      chk(dac_code, 16'h5678);
      wr(8'h28, 16'h0000);
      pulse;
      chk(dac_code, 16'h9ABC);
      // output write lands on the edge where the pin load fires
      wr(8'h33, 16'h3C3C);
      fork
         pulse;
         begin
            repeat (2) @(negedge ref_clk);
            wr(8'h29, 16'h0F0F);
         end
      join
      chk(dac_code, 16'h3C3C);
      rd(8'h29, 16'h3C3C);
      wr(8'h00, 16'hFFFF);
      rd(8'h00, 16'h0000);
      $display("load pin test done");
      finish_test;
   end
endmodule // dac_fast_mode_update_regs_bench
`default_nettype wire

// ===== tb/dac_props.sv
`timescale 1ns/100ps
`default_nettype none
module dac_props (
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        load_strobe_n,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [7:0]  addr,
   input wire logic [15:0] wr_data,
   input wire logic [15:0] rd_data,
   input wire logic        rd_valid,
   input wire logic [15:0] dac_code,
   input wire logic        dac_core_sleep,
   input wire logic        amp_sleep,
   input wire logic [2:0]  span_code,
   input wire logic        span_valid
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   wire pd = wr_en && addr == 8'h18;
   wire cw = wr_en && addr == 8'h29;
   // a pin fall sampled two edges back loads over the write, so those cycles are skipped
   chk_core_sleep: assert property (pd ##1 !pd
      |-> ##1 dac_core_sleep == $past(wr_data[4], 2))
      else $error("core sleep wrong");
   chk_amp_sleep: assert property (pd ##1 !pd |-> ##1 amp_sleep == $past(wr_data[0], 2))
      else $error("amp sleep wrong");
   chk_code_write: assert property (cw && $past(load_strobe_n, 2) ##1 !wr_en
      |-> ##1 dac_code == $past(wr_data, 2))
      else $error("output code wrong");
   chk_rd_answer: assert property (rd_en |=> rd_valid)
      else $error("read not answered");
   chk_rd_pulse: assert property (!rd_en |=> !rd_valid)
      else $error("stray read valid");
   chk_trig_zero: assert property (rd_en && addr == 8'h32 |=> rd_data == 16'h0000)
      else $error("trigger reads nonzero");
   chk_pd_reserved: assert property (rd_en && addr == 8'h18
      |=> rd_data[15:5] == 11'h000 && rd_data[3:1] == 3'h0)
      else $error("reserved bits set");
   chk_span_flag: assert property (span_code > 3'h4 |-> !span_valid)
      else $error("bad span flagged valid");
endmodule // dac_props
bind dac_fast_mode_update_regs dac_props u_props (.ref_clk(ref_clk), .nrst(nrst),
   .load_strobe_n(load_strobe_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
   .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .dac_code(dac_code),
   .dac_core_sleep(dac_core_sleep), .amp_sleep(amp_sleep), .span_code(span_code),
   .span_valid(span_valid));
`default_nettype wire

// ===== tb/reg_host.sv
`timescale 1ns/100ps
`default_nettype none
module reg_host (
   input  wire logic        ref_clk,
   input  wire logic [15:0] rd_data,
   output var  logic        wr_en,
   output var  logic        rd_en,
   output var  logic [7:0]  addr,
   output var  logic [15:0] wr_data
);
   initial begin
      {wr_en, rd_en, addr, wr_data} = 26'h0;
   end
   // idle bus shows inverted values so a stale copy is never seen
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
      output logic [15:0] q);
      @(negedge ref_clk);
      {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
      @(negedge ref_clk);
      q = rd_data;
      {wr_en, rd_en, addr, wr_data} = {2'h0, ~a, ~d};
      @(negedge ref_clk);
   endtask
endmodule // reg_host
`default_nettype wire
